//--- design/tmrcap_defines.svh
`ifndef TMRCAP_DEFINES_SVH
`define TMRCAP_DEFINES_SVH

// register byte addresses on the apb bus
`define TMRCAP_OFS_CTRL 8'h00
`define TMRCAP_OFS_STAT 8'h04
`define TMRCAP_OFS_MASK 8'h08
`define TMRCAP_OFS_COUNT 8'h0c
`define TMRCAP_OFS_CAPT 8'h10

// timer_control_reg field positions
`define TMRCAP_CTRL_RUN 0
`define TMRCAP_CTRL_SRC 1
`define TMRCAP_CTRL_EXEN 2
`define TMRCAP_CTRL_MODE_LO 3
`define TMRCAP_CTRL_MODE_HI 4
`define TMRCAP_CTRL_EXF 6
`define TMRCAP_CTRL_OVF 7

// status and interrupt_enable_reg bit positions (same layout)
`define TMRCAP_STAT_OVF 0
`define TMRCAP_STAT_EXF 1

// reset values
`define TMRCAP_RST_CTRL 5'h00
`define TMRCAP_RST_FLAGS 2'h0
`define TMRCAP_RST_COUNT 16'h0000
`define TMRCAP_RST_CAPT 16'h0000

// internal timing pulse divides the oscillator (sys_clk) by twelve
`define TMRCAP_DIV_RATIO 12
`define TMRCAP_DIV_LAST 4'hb
`define TMRCAP_COUNT_TOP 16'hffff

`endif

//--- design/tmrcap_pkg.sv
package tmrcap_pkg;

    // operating modes chosen by the mode field of timer_control_reg
    typedef enum logic [1:0] {
        TMRCAP_MODE_CAPTURE = 2'b00,
        TMRCAP_MODE_RELOAD = 2'b01,
        TMRCAP_MODE_BAUD = 2'b10,
        TMRCAP_MODE_SPARE = 2'b11
    } tmrcap_mode_type;

    // state of the pin synchroniser
    typedef struct packed {
        logic meta;
        logic stable;
        logic prev;
    } tmrcap_sync_type;

    // whole state of the timer block
    typedef struct packed {
        logic rstMeta;
        logic rstSync;
        logic run;
        logic countSourceSelect;
        logic externalEdgeEnable;
        tmrcap_mode_type mode;
        logic [15:0] count;
        logic [15:0] capture;
        logic [1:0] stat;
        logic [1:0] mask;
        logic [3:0] divCnt;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tmrcap_state_type;

endpackage : tmrcap_pkg

//--- design/tmrcap_edge_sync.sv
module tmrcap_edge_sync (
    // clock and synchronised reset
    input wire logic clk,
    input wire logic rstn,
    // raw pin and its falling edge
    input wire logic pinIn,
    output logic fallPulse
);
    import tmrcap_pkg::*;

    tmrcap_sync_type s_q;
    tmrcap_sync_type s_d;

    // two flops then one history flop; only the stable copy is compared
    // two-sample fall detect
    always_comb begin
        s_d = s_q;
        s_d.meta = pinIn;
        s_d.stable = s_q.meta;
        s_d.prev = s_q.stable;
    end

    // idle level is high, so reset to ones to avoid a false edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= 3'b111;
        end else begin
            s_q <= s_d;
        end
    end

    assign fallPulse = s_q.prev & ~s_q.stable;

endmodule : tmrcap_edge_sync

//--- design/tmrcap_top.sv
// Function
// - 16-bit count; select bit picks internal pulses or external events.
// - three modes selected in control register: capture, auto-reload, baud generation.
// - capture mode with edge enable clear is a plain timer setting overflow flag.
// - overflow requests an interrupt only when its enable bit is set.
// - in capture mode with edge enable set, trigger falling edge copies count into capture registers.
// - each enabled trigger edge outside baud mode sets the external edge flag; overflow unchanged.
// - edge flag raises the same interrupt; software reads both flags.
// - capture mode never reloads count; counting continues through captures.
// - trigger pin transitions ignored while edge enable is clear.
`include "tmrcap_defines.svh"

module tmrcap_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins
    input wire logic externalTriggerPin,
    input wire logic externalCountPin,
    // interrupt
    output logic timerIrq
);
    import tmrcap_pkg::*;

    tmrcap_state_type s_q;
    tmrcap_state_type s_d;

    logic rstn;
    logic trigFall;
    logic countFall;
    logic tick;
    logic countEvent;
    logic overflowEvent;
    logic captureEvent;
    logic reloadEvent;
    logic access;
    logic accessWrite;
    logic wrCtrl;
    logic wrStat;
    logic wrMask;
    logic wrCount;
    logic wrCapt;
    logic addrHit;
    logic [31:0] readWord;
    logic [1:0] flagSet;

    // the rest of the design runs on the synchronised reset copy
    assign rstn = s_q.rstSync;

    // trigger pin and external count pin each get their own edge detector instance
    tmrcap_edge_sync u_trig_sync (
        .clk(sys_clk),
        .rstn(rstn),
        .pinIn(externalTriggerPin),
        .fallPulse(trigFall)
    );

    tmrcap_edge_sync u_count_sync (
        .clk(sys_clk),
        .rstn(rstn),
        .pinIn(externalCountPin),
        .fallPulse(countFall)
    );

    // source select picks divided clock or external events
    assign tick = s_q.countSourceSelect ? countFall : (s_q.divCnt == `TMRCAP_DIV_LAST);
    assign countEvent = s_q.run & tick;

    assign overflowEvent = countEvent & (s_q.count == `TMRCAP_COUNT_TOP);

    assign captureEvent = trigFall & s_q.externalEdgeEnable
        & (s_q.mode == TMRCAP_MODE_CAPTURE);
    assign reloadEvent = trigFall & s_q.externalEdgeEnable & (s_q.mode == TMRCAP_MODE_RELOAD);

    // apb: the write lands on the edge where pready is seen high
    assign access = psel & penable & s_q.pready;
    assign accessWrite = access & pwrite;

    // address decode for writes
    assign wrCtrl = accessWrite & (paddr == `TMRCAP_OFS_CTRL);
    assign wrStat = accessWrite & (paddr == `TMRCAP_OFS_STAT);
    assign wrMask = accessWrite & (paddr == `TMRCAP_OFS_MASK);
    assign wrCount = accessWrite & (paddr == `TMRCAP_OFS_COUNT);
    assign wrCapt = accessWrite & (paddr == `TMRCAP_OFS_CAPT);

    // read mux; unmapped addresses read zero and flag an error
    always_comb begin
        readWord = 32'h0000_0000;
        addrHit = 1'b1;
        if (paddr == `TMRCAP_OFS_CTRL) begin
            readWord[`TMRCAP_CTRL_RUN] = s_q.run;
            readWord[`TMRCAP_CTRL_SRC] = s_q.countSourceSelect;
            readWord[`TMRCAP_CTRL_EXEN] = s_q.externalEdgeEnable;
            readWord[`TMRCAP_CTRL_MODE_HI:`TMRCAP_CTRL_MODE_LO] = s_q.mode;
            readWord[`TMRCAP_CTRL_EXF] = s_q.stat[`TMRCAP_STAT_EXF];
            readWord[`TMRCAP_CTRL_OVF] = s_q.stat[`TMRCAP_STAT_OVF];
        end else if (paddr == `TMRCAP_OFS_STAT) begin
            readWord[1:0] = s_q.stat;
        end else if (paddr == `TMRCAP_OFS_MASK) begin
            readWord[1:0] = s_q.mask;
        end else if (paddr == `TMRCAP_OFS_COUNT) begin
            readWord[15:0] = s_q.count;
        end else if (paddr == `TMRCAP_OFS_CAPT) begin
            readWord[15:0] = s_q.capture;
        end else begin
            addrHit = 1'b0;
        end
    end

    // next state of the whole block
    always_comb begin
        s_d = s_q;
        flagSet = 2'b00;
        s_d.rstMeta = 1'b1;
        s_d.rstSync = s_q.rstMeta;

        // free-running divide by twelve of the oscillator
        if (s_q.divCnt == `TMRCAP_DIV_LAST) begin
            s_d.divCnt = 4'h0;
        end else begin
            s_d.divCnt = s_q.divCnt + 4'h1;
        end

        // mode decides what an overflow or an edge does to the count
        if (countEvent) begin
            s_d.count = s_q.count + 16'h0001;
        end
        case (s_q.mode)
            TMRCAP_MODE_CAPTURE: begin
                if (overflowEvent) begin
                    flagSet[`TMRCAP_STAT_OVF] = 1'b1;
                end
                if (captureEvent) begin
                    s_d.capture = s_q.count;
                end
            end
            TMRCAP_MODE_RELOAD: begin
                if (overflowEvent) begin
                    flagSet[`TMRCAP_STAT_OVF] = 1'b1;
                end
                if (overflowEvent || reloadEvent) begin
                    s_d.count = s_q.capture;
                end
            end
            TMRCAP_MODE_BAUD: begin
                // overflows only pace the reload here; no flag
                if (overflowEvent) begin
                    s_d.count = s_q.capture;
                end
            end
            default: begin
                s_d.count = s_q.count;
            end
        endcase

        // enabled edge outside baud mode sets the external edge flag
        if (trigFall && s_q.externalEdgeEnable && (s_q.mode != TMRCAP_MODE_BAUD)) begin
            flagSet[`TMRCAP_STAT_EXF] = 1'b1;
        end

        // software writes; a count write overrides the increment
        if (wrCtrl) begin
            s_d.run = pwdata[`TMRCAP_CTRL_RUN];
            s_d.countSourceSelect = pwdata[`TMRCAP_CTRL_SRC];
            s_d.externalEdgeEnable = pwdata[`TMRCAP_CTRL_EXEN];
            s_d.mode = tmrcap_mode_type'(pwdata[`TMRCAP_CTRL_MODE_HI:`TMRCAP_CTRL_MODE_LO]);
        end
        if (wrMask) begin
            s_d.mask = pwdata[1:0];
        end
        if (wrCount) begin
            s_d.count = pwdata[15:0];
        end
        if (wrCapt) begin
            s_d.capture = pwdata[15:0];
        end

        // flags stay until software clears them; a new event wins
        if (wrStat) begin
            s_d.stat = (s_q.stat & ~pwdata[1:0]) | flagSet;
        end else begin
            s_d.stat = s_q.stat | flagSet;
        end

        s_d.irq = |(s_q.stat & s_q.mask);

        // one wait state so that every bus output comes from a flop
        s_d.pready = psel & penable & ~s_q.pready;
        if (psel && penable && !s_q.pready) begin
            s_d.prdata = pwrite ? 32'h0000_0000 : readWord;
            s_d.pslverr = ~addrHit;
        end else begin
            s_d.prdata = 32'h0000_0000;
            s_d.pslverr = 1'b0;
        end
    end

    // reset meta flop takes a constant one, the sync flop copies it; the rest clears with them
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else if (!s_q.rstSync) begin
            s_q <= '0;
            s_q.rstMeta <= 1'b1;
            s_q.rstSync <= s_q.rstMeta;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign timerIrq = s_q.irq;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // internal pulses arrive every twelve clocks
    // watches the divider itself, so a source switch mid-period cannot trip it
    chk_div_twelve: assert property (
        (s_q.divCnt == `TMRCAP_DIV_LAST) |-> ##12 (s_q.divCnt == `TMRCAP_DIV_LAST)
    ) else $error("internal tick period is not twelve clocks");

    // auto-reload mode loads the capture value on overflow
    chk_reload_load: assert property (
        (overflowEvent && s_q.mode == TMRCAP_MODE_RELOAD && !wrCount)
        |=> (s_q.count == $past(s_q.capture))
    ) else $error("reload mode did not load the capture value");

    // baud mode paces reloads but never raises a flag
    chk_baud_quiet: assert property (
        (s_q.mode == TMRCAP_MODE_BAUD && !wrStat && (s_q.stat == 2'b00))
        |=> (s_q.stat == 2'b00)
    ) else $error("baud mode raised a timer flag");

    // wrap to zero with the flag
    chk_ovf_wrap: assert property (
        (overflowEvent && s_q.mode == TMRCAP_MODE_CAPTURE && !wrCount)
        |=> (s_q.count == 16'h0000) && s_q.stat[`TMRCAP_STAT_OVF]
    ) else $error("overflow did not wrap and flag");

    chk_ovf_sticky: assert property (
        (s_q.stat[`TMRCAP_STAT_OVF] && !wrStat) |=> s_q.stat[`TMRCAP_STAT_OVF]
    ) else $error("overflow flag lost without a clear");

    chk_capture_copy: assert property (
        (captureEvent && !wrCapt) |=> (s_q.capture == $past(s_q.count))
    ) else $error("capture register does not hold the count");

    // edge flag follows an enabled edge
    chk_edge_flag: assert property (
        (trigFall && s_q.externalEdgeEnable && s_q.mode == TMRCAP_MODE_CAPTURE)
        |=> s_q.stat[`TMRCAP_STAT_EXF]
    ) else $error("edge flag not set by enabled edge");

    chk_edge_ignored: assert property (
        (!s_q.externalEdgeEnable && !wrCapt && !s_q.stat[`TMRCAP_STAT_EXF])
        |=> $stable(s_q.capture) && !s_q.stat[`TMRCAP_STAT_EXF]
    ) else $error("trigger acted while edge enable clear");

    chk_no_reload: assert property (
        (countEvent && s_q.mode == TMRCAP_MODE_CAPTURE && !wrCount)
        |=> (s_q.count == $past(s_q.count) + 16'h0001)
    ) else $error("capture mode count did not step by one");

    // request follows enabled flags one clock later
    chk_irq_gate: assert property (
        ##1 (timerIrq == $past(|(s_q.stat & s_q.mask)))
    ) else $error("interrupt does not match enabled flags");

    // edge flag alone can raise the request
    chk_edge_irq: assert property (
        (s_q.stat[`TMRCAP_STAT_EXF] && s_q.mask[`TMRCAP_STAT_EXF]) |=> timerIrq
    ) else $error("edge flag did not raise interrupt");

    // a capture needs the pin high three clocks back and low two clocks back
    chk_sync_fall: assert property (
        captureEvent |-> $past(externalTriggerPin, 3) && !$past(externalTriggerPin, 2)
    ) else $error("capture without a synchronised falling edge");

    // the bus answers one clock into the access phase
    chk_apb_wait: assert property (
        (psel && penable && !pready) |=> pready
    ) else $error("apb access not answered after one wait state");

endmodule : tmrcap_top

//--- tb/tmrcap_pin_model.sv
module tmrcap_pin_model (
    // clock
    input wire logic clk,
    // pins driven toward the timer
    output logic trigPin,
    output logic countPin
);
    timeunit 1ns;
    timeprecision 1ps;

    // pins idle high, as the port pull-ups hold them
    initial begin
        trigPin = 1'b1;
        countPin = 1'b1;
    end

    // low then back high
    // each level held four clocks so the synchroniser sees one high and one low sample
    task automatic fall(input bit onTrig);
        @(posedge clk);
        if (onTrig) trigPin <= 1'b0;
        else countPin <= 1'b0;
        repeat (4) @(posedge clk);
        trigPin <= 1'b1;
        countPin <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : fall
endmodule : tmrcap_pin_model

//--- tb/testbench.sv
`include "tmrcap_defines.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic sysClk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, timerIrq, trigPin, countPin;
    logic [15:0] mCount = 16'h0, mCapt = 16'h0;
    logic [1:0] mStat = 2'h0;
    logic [4:0] mCtrl = 5'h0;
    logic [31:0] seed = 32'h2f23;
    int mismatches = 0, checked = 0, cyc = 0;

    `define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end

    always #20 sysClk = ~sysClk;

    tmrcap_top dut (.sys_clk(sysClk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .externalTriggerPin(trigPin), .externalCountPin(countPin),
        .timerIrq(timerIrq));

    tmrcap_pin_model pins (.clk(sysClk), .trigPin(trigPin), .countPin(countPin));

    task automatic conclude();
        $display("mismatches=%0d checked=%0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude

    // hang guard: the whole run needs well under this many cycles
    always @(posedge sysClk) begin
        cyc++;
        if (cyc >= 20000) begin
            mismatches++;
            conclude();
        end
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sysClk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sysClk);
        penable <= 1'b1;
        // no local limit: only the cycle guard ends a hung wait
        do begin
            @(posedge sysClk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask : rdChk

    task automatic setCtrl(input logic [4:0] c);
        mCtrl = c;
        wr(`TMRCAP_OFS_CTRL, {27'h0, c});
    endtask : setCtrl

    // control read shows the overflow flag at bit 7 and the edge flag at bit 6
    function automatic logic [31:0] ctrlExp();
        return {24'h0, mStat[0], mStat[1], 1'b0, mCtrl};
    endfunction : ctrlExp

    task automatic settle();
        repeat (3) @(posedge sysClk);
    endtask : settle

    initial begin
        repeat (20) @(posedge sysClk);
        resetn <= 1'b1;
        repeat (4) @(posedge sysClk);
        rdChk(`TMRCAP_OFS_CTRL, 32'h0);
        rdChk(`TMRCAP_OFS_STAT, 32'h0);
        rdChk(`TMRCAP_OFS_MASK, 32'h0);
        rdChk(`TMRCAP_OFS_COUNT, 32'h0);
        rdChk(`TMRCAP_OFS_CAPT, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        `CHK(er, 1'b1)
        `CHK(rd, 32'h0)
        for (int m = 1; m < 4; m++) begin
            setCtrl({m[1:0], 3'h0});
            rdChk(`TMRCAP_OFS_CTRL, ctrlExp());
        end
        // external counting across the wrap, capture disabled
        setCtrl(5'h03);
        mCount = 16'hfffe;
        wr(`TMRCAP_OFS_COUNT, {16'h0, mCount});
        repeat (3) begin
            pins.fall(1'b0);
            mCount++;
            if (mCount == 16'h0) mStat[0] = 1'b1;
        end
        rdChk(`TMRCAP_OFS_COUNT, {16'h0, mCount});
        rdChk(`TMRCAP_OFS_STAT, {30'h0, mStat});
        `CHK(timerIrq, 1'b0)
        wr(`TMRCAP_OFS_MASK, 32'h1);
        settle();
        `CHK(timerIrq, 1'b1)
        wr(`TMRCAP_OFS_STAT, 32'h1);
        mStat = 2'h0;
        settle();
        `CHK(timerIrq, 1'b0)
        pins.fall(1'b1);
        rdChk(`TMRCAP_OFS_CAPT, {16'h0, mCapt});
        rdChk(`TMRCAP_OFS_STAT, {30'h0, mStat});
        wr(`TMRCAP_OFS_MASK, 32'h2);
        // captures at random counts; counting carries on afterwards
        repeat (4) begin
            mCount = 16'(xs());
            wr(`TMRCAP_OFS_COUNT, {16'h0, mCount});
            setCtrl(5'h07);
            pins.fall(1'b1);
            mCapt = mCount;
            mStat[1] = 1'b1;
            rdChk(`TMRCAP_OFS_CAPT, {16'h0, mCapt});
            rdChk(`TMRCAP_OFS_CTRL, ctrlExp());
            pins.fall(1'b0);
            mCount++;
            rdChk(`TMRCAP_OFS_COUNT, {16'h0, mCount});
            `CHK(timerIrq, 1'b1)
            wr(`TMRCAP_OFS_STAT, 32'h3);
            mStat = 2'h0;
            settle();
            `CHK(timerIrq, 1'b0)
        end
        // auto-reload: overflow and an enabled edge both load the capture value
        mCapt = 16'h1234;
        wr(`TMRCAP_OFS_CAPT, {16'h0, mCapt});
        setCtrl(5'h0b);
        wr(`TMRCAP_OFS_COUNT, 32'hffff);
        pins.fall(1'b0);
        rdChk(`TMRCAP_OFS_COUNT, {16'h0, mCapt});
        rdChk(`TMRCAP_OFS_STAT, 32'h1);
        setCtrl(5'h0f);
        wr(`TMRCAP_OFS_COUNT, 32'h0050);
        pins.fall(1'b1);
        rdChk(`TMRCAP_OFS_COUNT, {16'h0, mCapt});
        rdChk(`TMRCAP_OFS_STAT, 32'h3);
        wr(`TMRCAP_OFS_STAT, 32'h3);
        // baud: overflow reloads, neither overflow nor edge raises a flag
        setCtrl(5'h17);
        wr(`TMRCAP_OFS_COUNT, 32'hffff);
        pins.fall(1'b0);
        pins.fall(1'b1);
        rdChk(`TMRCAP_OFS_COUNT, {16'h0, mCapt});
        rdChk(`TMRCAP_OFS_STAT, 32'h0);
        // internal pulses: one count per twelve clocks, phase unknown
        setCtrl(5'h01);
        wr(`TMRCAP_OFS_COUNT, 32'h0);
        repeat (120) @(posedge sysClk);
        apb(1'b0, `TMRCAP_OFS_COUNT, 32'h0);
        `CHK(rd >= 32'd9 && rd <= 32'd11, 1'b1)
        conclude();
    end
endmodule : testbench
